// ===== hw/pwit_timer.sv
// pulse width / interval timer: 8-bit down counter with reload and
// one-shot interval modes and a pulse width measurement mode.
// assumes an AHB-Lite master on clk_i and a pulse input that is already
// on clk_i's timing grid (re-sampled here anyway before edge detection).
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - interval mode counts down, flags one-to-zero wrap
// - irq when allowed and any flag set
// - writing zero clears wrap and done flags
// - no wrap flag if run cleared simultaneously
// - allowing irq with pending flag fires immediately
// - completion edge captures count, sets flags, re-arms
// - measurement wrap sets flag, counting continues
// - buffer read in measurement clears held flag
// - no done/held flags if run cleared simultaneously
// - interval start loads buffer, then counts on ticks
// - reload mode: toggle output, reload, flag
// - one-shot: toggle output, stop, flag
// - reload value one toggles every tick
// - wrap flag set regardless of irq allow
// - stopped timer holds output bit
// - measurement starts from FF on start edge
// - high width waits for fresh rising edge
// - held flag set keeps old capture
// - edge select picks measured interval
// - function bit picks interval or measurement
// - one-shot bit picks mode, interval only
module pwit_timer (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire pwit_pkg::pwit_ahb_req_s ahb_i,
  output var  pwit_pkg::pwit_ahb_rsp_s ahb_o,
  input  wire logic                   pulse_input_pin_i,
  output logic                        pulse_out_o,
  output logic                        timer_irq_line_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                       run;
  logic                       irq_allow_bit;
  logic                       wrap_flag;
  logic                       measure_done_flag;
  logic                       capture_held_flag;
  logic                       function_select_bit;
  logic                       oneshot_select_bit;
  logic                       pulse_out_bit;
  logic [1:0]                 clk_sel;
  logic [1:0]                 edge_sel;
  logic [7:0]                 reload_capture_buffer;
  logic [7:0]                 count;
  pwit_pkg::pwit_state_e      state;
  logic [pwit_pkg::PRESC_W-1:0] presc;
  logic                       pin_meta;
  logic                       pin_sync;
  logic                       pin_last;
  logic                       dp_write;
  logic                       dp_read;
  logic [7:0]                 dp_addr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire addr_take = ahb_i.hsel & ahb_i.hready & (ahb_i.htrans == pwit_pkg::HTRANS_NONSEQ);
  wire [7:0] wd  = ahb_i.hwdata[7:0];
  wire wr_ctrl   = dp_write & (dp_addr == pwit_pkg::ADDR_CTRL_STATUS);
  wire wr_mode   = dp_write & (dp_addr == pwit_pkg::ADDR_MODE_CONFIG);
  wire wr_buf    = dp_write & (dp_addr == pwit_pkg::ADDR_RELOAD_CAP);
  // reads are sampled one cycle late so a write just before is seen
  wire rd_fire   = dp_read & ~ahb_o.hreadyout;
  wire rd_buf    = rd_fire & (dp_addr == pwit_pkg::ADDR_RELOAD_CAP);

  wire [7:0] ctrl_view = {run, 1'b0, irq_allow_bit, 2'b00,
                          wrap_flag, measure_done_flag, capture_held_flag};
  wire [7:0] mode_view = {function_select_bit, oneshot_select_bit, pulse_out_bit,
                          1'b0, clk_sel, edge_sel};
  wire [7:0] rd_byte =
    (dp_addr == pwit_pkg::ADDR_CTRL_STATUS) ? ctrl_view :
    (dp_addr == pwit_pkg::ADDR_MODE_CONFIG) ? mode_view :
    (dp_addr == pwit_pkg::ADDR_RELOAD_CAP)  ? reload_capture_buffer :
    (dp_addr == pwit_pkg::ADDR_COUNT)       ? count : 8'h00;

  // ----------------------------------------------------------------
  // count clock enable and input edges
  // ----------------------------------------------------------------
  wire [pwit_pkg::PRESC_W-1:0] presc_mask =
    (clk_sel == 2'h0) ? pwit_pkg::PRESC_MASK0 :
    (clk_sel == 2'h1) ? pwit_pkg::PRESC_MASK1 :
    pwit_pkg::PRESC_MASK2;
  // code three is forbidden; it is treated as the slowest clock
  wire tick     = ((presc & presc_mask) == presc_mask);
  wire pin_rise = pin_sync & ~pin_last;
  wire pin_fall = ~pin_sync & pin_last;

  // start and completion edges per edge select code
  wire start_edge =
    (edge_sel == pwit_pkg::EDGE_HIGH_W) ? pin_rise :
    (edge_sel == pwit_pkg::EDGE_LOW_W)  ? pin_fall :
    (edge_sel == pwit_pkg::EDGE_RISE_R) ? pin_rise : pin_fall;
  wire end_edge =
    (edge_sel == pwit_pkg::EDGE_HIGH_W) ? pin_fall :
    (edge_sel == pwit_pkg::EDGE_LOW_W)  ? pin_rise :
    (edge_sel == pwit_pkg::EDGE_RISE_R) ? pin_rise : pin_fall;
  // in period modes the completion edge is also the next start
  wire period_mode = edge_sel[1];

  // ----------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------
  wire run_stop  = wr_ctrl & ~wd[pwit_pkg::POS_RUN];
  wire run_start = wr_ctrl & wd[pwit_pkg::POS_RUN] & ~run;
  wire meas      = function_select_bit;
  wire counting  = run & (state == pwit_pkg::PWIT_COUNT);
  wire wrap_now  = counting & tick & (count == pwit_pkg::COUNT_ONE);
  wire complete  = run & meas & (state == pwit_pkg::PWIT_COUNT) & end_edge;

  // events are dropped when software stops the timer in the same cycle
  wire set_wrap  = wrap_now & ~run_stop;
  wire set_done  = complete & ~run_stop;
  wire oneshot_end = wrap_now & ~meas & oneshot_select_bit;

  pwit_pkg::pwit_state_e next_state;
  logic [7:0]            next_count;
  logic                  next_run;

  always_comb begin
    next_state = state;
    next_count = count;
    next_run   = run;
    if (wr_ctrl) begin
      next_run = wd[pwit_pkg::POS_RUN];
    end
    if (run_start) begin
      if (meas) begin
        next_state = pwit_pkg::PWIT_ARMED;
      end else begin
        next_state = pwit_pkg::PWIT_COUNT;
        next_count = reload_capture_buffer;
      end
    end else if (!run || run_stop) begin
      next_state = pwit_pkg::PWIT_IDLE;
    end else begin
      case (state)
        pwit_pkg::PWIT_IDLE: begin
          next_state = pwit_pkg::PWIT_IDLE;
        end
        pwit_pkg::PWIT_ARMED: begin
          if (start_edge) begin
            next_state = pwit_pkg::PWIT_COUNT;
            next_count = pwit_pkg::COUNT_START;
          end
        end
        pwit_pkg::PWIT_COUNT: begin
          if (complete) begin
            // re-arm for continuous measurement
            if (period_mode) begin
              next_count = pwit_pkg::COUNT_START;
            end else begin
              next_state = pwit_pkg::PWIT_ARMED;
            end
          end else if (wrap_now && !meas) begin
            if (oneshot_select_bit) begin
              next_run   = 1'b0;
              next_state = pwit_pkg::PWIT_IDLE;
              next_count = 8'h00;
            end else begin
              next_count = reload_capture_buffer;
            end
          end else if (tick) begin
            // in measurement the count wraps through zero
            next_count = count - 8'h01;
          end
        end
        default: begin
          next_state = pwit_pkg::PWIT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc    <= '0;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      presc    <= presc + 1'b1;
      pin_meta <= pulse_input_pin_i;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= pwit_pkg::PWIT_IDLE;
      count <= 8'h00;
      run   <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      run   <= next_run;
    end
  end

  // flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_allow_bit     <= 1'b0;
      wrap_flag         <= 1'b0;
      measure_done_flag <= 1'b0;
      capture_held_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        irq_allow_bit <= wd[pwit_pkg::POS_IRQ_ALLOW];
      end
      if (set_wrap) begin
        wrap_flag <= 1'b1;
      end else if (wr_ctrl && !wd[pwit_pkg::POS_WRAP]) begin
        wrap_flag <= 1'b0;
      end
      if (set_done) begin
        measure_done_flag <= 1'b1;
      end else if (wr_ctrl && !wd[pwit_pkg::POS_MEAS_DONE]) begin
        measure_done_flag <= 1'b0;
      end
      if (set_done) begin
        capture_held_flag <= 1'b1;
      end else if (rd_buf && meas) begin
        capture_held_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      function_select_bit   <= pwit_pkg::RST_MODE_CONFIG[pwit_pkg::POS_FUNC_SEL];
      oneshot_select_bit    <= pwit_pkg::RST_MODE_CONFIG[pwit_pkg::POS_ONESHOT];
      pulse_out_bit         <= pwit_pkg::RST_MODE_CONFIG[pwit_pkg::POS_PULSE_OUT];
      clk_sel               <= pwit_pkg::RST_MODE_CONFIG[pwit_pkg::POS_CLK_SEL +: 2];
      edge_sel              <= pwit_pkg::RST_MODE_CONFIG[pwit_pkg::POS_EDGE_SEL +: 2];
      reload_capture_buffer <= pwit_pkg::RST_RELOAD_CAP;
    end else begin
      if (wr_mode) begin
        function_select_bit <= wd[pwit_pkg::POS_FUNC_SEL];
        oneshot_select_bit  <= wd[pwit_pkg::POS_ONESHOT];
        clk_sel             <= wd[pwit_pkg::POS_CLK_SEL +: 2];
        edge_sel            <= wd[pwit_pkg::POS_EDGE_SEL +: 2];
      end
      // output toggles only on a wrap, so a stopped timer holds it
      if (wrap_now && !run_stop) begin
        pulse_out_bit <= ~pulse_out_bit;
      end else if (wr_mode) begin
        pulse_out_bit <= wd[pwit_pkg::POS_PULSE_OUT];
      end
      // a held capture is never overwritten by a new capture
      if (set_done && !capture_held_flag) begin
        reload_capture_buffer <= count;
      end else if (wr_buf && !meas) begin
        reload_capture_buffer <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_write         <= 1'b0;
      dp_read          <= 1'b0;
      dp_addr          <= 8'h00;
      ahb_o            <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
      pulse_out_o      <= 1'b0;
      timer_irq_line_o <= 1'b0;
    end else begin
      if (addr_take) begin
        dp_write <= ahb_i.hwrite;
        dp_read  <= ~ahb_i.hwrite;
        dp_addr  <= ahb_i.haddr[7:0];
      end else if (ahb_o.hreadyout) begin
        dp_write <= 1'b0;
        dp_read  <= 1'b0;
      end
      ahb_o.hreadyout <= ~(addr_take & ~ahb_i.hwrite);
      if (rd_fire) begin
        ahb_o.hrdata <= {24'h00_0000, rd_byte};
      end
      pulse_out_o      <= pulse_out_bit;
      timer_irq_line_o <= irq_allow_bit &
                          (wrap_flag | measure_done_flag | capture_held_flag);
    end
  end

endmodule // pwit_timer

`default_nettype wire

// ===== hw/pwit_pkg.sv
// package for the pulse width / interval timer: register map, field
// positions, reset values, states and the bus carriers.
// assumes a single 32-bit AHB-Lite slave port, word accesses only.
package pwit_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_CAP  = 8'h08;
  localparam logic [7:0] ADDR_COUNT       = 8'h0C;

  // ----------------------------------------------------------------
  // ctrl_status_reg fields
  // ----------------------------------------------------------------
  localparam int POS_RUN        = 7;
  localparam int POS_IRQ_ALLOW  = 5;
  localparam int POS_WRAP       = 2;
  localparam int POS_MEAS_DONE  = 1;
  localparam int POS_CAP_HELD   = 0;

  // ----------------------------------------------------------------
  // mode_config_reg fields
  // ----------------------------------------------------------------
  localparam int POS_FUNC_SEL   = 7;
  localparam int POS_ONESHOT    = 6;
  localparam int POS_PULSE_OUT  = 5;
  localparam int POS_CLK_SEL    = 2;
  localparam int POS_EDGE_SEL   = 0;

  // ----------------------------------------------------------------
  // reset values and count constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_RELOAD_CAP  = 8'h00;
  localparam logic [7:0] COUNT_ONE       = 8'h01;
  localparam logic [7:0] COUNT_START     = 8'hFF;

  // edge select codes
  localparam logic [1:0] EDGE_HIGH_W = 2'h0;
  localparam logic [1:0] EDGE_LOW_W  = 2'h1;
  localparam logic [1:0] EDGE_RISE_R = 2'h2;
  localparam logic [1:0] EDGE_FALL_F = 2'h3;

  // prescaler masks for the three count clocks (count every 2, 8, 32 cycles)
  localparam int PRESC_W = 5;
  localparam logic [PRESC_W-1:0] PRESC_MASK0 = 5'h01;
  localparam logic [PRESC_W-1:0] PRESC_MASK1 = 5'h07;
  localparam logic [PRESC_W-1:0] PRESC_MASK2 = 5'h1F;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    PWIT_IDLE  = 3'b001,
    PWIT_ARMED = 3'b010,
    PWIT_COUNT = 3'b100
  } pwit_state_e;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } pwit_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pwit_ahb_rsp_s;

endpackage

// ===== tb/pwit_chk.sv
// concurrent checks on the timer's bus port, interrupt line and pulse output
// assumes a single AHB-Lite master whose hready is the block's own hreadyout
`timescale 1ns/1ns
`default_nettype none
module pwit_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire pwit_pkg::pwit_ahb_req_s ahb_i,
  input wire pwit_pkg::pwit_ahb_rsp_s ahb_o,
  input wire logic                    pulse_input_pin_i,
  input wire logic                    pulse_out_o,
  input wire logic                    timer_irq_line_o
);
  // ----------------------------------------------------------------
  // transfer decode
  // ----------------------------------------------------------------
  wire logic tk = ahb_i.hsel & ahb_i.hready & (ahb_i.htrans == pwit_pkg::HTRANS_NONSEQ);
  wire logic rd = tk & ~ahb_i.hwrite;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  okay_resp_a: assert property (ahb_o.hresp == 1'b0)
    else $error("bus response is not okay");
  read_wait_a: assert property (rd |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
    else $error("read data phase is not two cycles");
  write_nowait_a: assert property (tk && ahb_i.hwrite |=> ahb_o.hreadyout)
    else $error("write data phase stalled");
  wait_only_read_a: assert property (!ahb_o.hreadyout |-> $past(rd))
    else $error("wait state without a read");
  rdata_upper_a: assert property (ahb_o.hreadyout |-> ahb_o.hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_stands_a: assert property ($changed(ahb_o.hrdata) |-> $past(rd, 1) || $past(rd, 2))
    else $error("read data changed outside a read");
  // flags are sticky, so the line can only drop after a software access
  irq_fall_cause_a: assert property (
    $fell(timer_irq_line_o) |-> $past(tk, 3) || $past(tk, 4))
    else $error("interrupt dropped without an access");
  out_spacing_a: assert property ($changed(pulse_out_o) |=> $stable(pulse_out_o))
    else $error("pulse output toggled on adjacent cycles");

  read_seen_c: cover property (rd);
  irq_drop_c: cover property ($fell(timer_irq_line_o));
  out_toggle_c: cover property ($changed(pulse_out_o));
endmodule // pwit_chk

bind pwit_timer pwit_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ahb_i(ahb_i), .ahb_o(ahb_o),
  .pulse_input_pin_i(pulse_input_pin_i), .pulse_out_o(pulse_out_o),
  .timer_irq_line_o(timer_irq_line_o));
`default_nettype wire

// ===== tb/pwit_pulse_src.sv
// model of the measured pulse source driving the timer's input pin
// assumes lengths given in clk_i cycles and changed only between pulses
`timescale 1ns/1ns
`default_nettype none
module pwit_pulse_src (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] hi_len_i,
  input  wire logic [15:0] lo_len_i,
  output var  logic        pin_o
);
  logic [15:0] cnt;

  // a disabled source idles low, so it makes no edges of its own
  always @(posedge clk_i) begin
    if (!en_i) begin
      pin_o <= 1'b0;
      cnt <= 16'h0001;
    end else if (cnt >= (pin_o ? hi_len_i : lo_len_i)) begin
      pin_o <= ~pin_o;
      cnt <= 16'h0001;
    end else
      cnt <= cnt + 16'h0001;
  end
endmodule // pwit_pulse_src
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the pulse width / interval timer
// assumes the timer on a 125 MHz clock with the pulse source model on its pin
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [7:0]  CS = pwit_pkg::ADDR_CTRL_STATUS;
  localparam logic [7:0]  MC = pwit_pkg::ADDR_MODE_CONFIG;
  localparam logic [7:0]  RB = pwit_pkg::ADDR_RELOAD_CAP;
  localparam logic [23:0] TV [7] = '{24'h04F7E7, 24'h040000, 24'h002720, 24'h000000,
                                     24'h0CFF00, 24'h10FF00, 24'h085A5A};
  localparam logic [15:0] RT [3] = '{16'h0102, 16'h1528, 16'h2240};
  localparam logic [55:0] MT [5] = '{{8'h00, 16'h0014, 16'h0028, 16'h000A},
                                     {8'h02, 16'h0014, 16'h0028, 16'h001E},
                                     {8'h03, 16'h001E, 16'h0032, 16'h0028},
                                     {8'h01, 16'h0014, 16'h0028, 16'h0014},
                                     {8'h00, 16'h0258, 16'h0028, 16'h012C}};
  logic                         clk_i;
  logic                         rst_i;
  pwit_pkg::pwit_ahb_req_s      req;
  pwit_pkg::pwit_ahb_rsp_s      rsp;
  wire pwit_pkg::pwit_ahb_req_s ahb_in;
  logic                         pin, pout, irq, src_en, rdy_s;
  logic [31:0]                  rdat_s;
  logic [15:0]                  hi_len, lo_len;
  int                           err_count, samples_checked;

  assign ahb_in = {req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, rsp.hreadyout,
                   req.hwdata};
  pwit_timer uut (.clk_i(clk_i), .rst_i(rst_i), .ahb_i(ahb_in), .ahb_o(rsp),
    .pulse_input_pin_i(pin), .pulse_out_o(pout), .timer_irq_line_o(irq));
  pwit_pulse_src src (.clk_i(clk_i), .en_i(src_en), .hi_len_i(hi_len), .lo_len_i(lo_len),
    .pin_o(pin));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // registered outputs are steady at the falling edge
  always @(negedge clk_i) begin
    rdy_s <= rsp.hreadyout;
    rdat_s <= rsp.hrdata;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    err_count++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    req.haddr <= {24'h000000, a};
    req.hwrite <= w;
    req.htrans <= pwit_pkg::HTRANS_NONSEQ;
    do @(posedge clk_i); while (rdy_s !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= {24'h000000, d};
    do @(posedge clk_i); while (rdy_s !== 1'b1);
    q = rdat_s[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task automatic wait_out(output int n);
    logic v;
    v = pout;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (pout === v && n < 2000);
    if (n >= 2000) fail("pulse output never toggled");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] q;
    for (int a = 0; a < 16; a += 4) begin
      rd(8'(a), q);
      chk(q, 8'h00, "register reset value");
    end
    foreach (TV[i]) begin
      wr(TV[i][23:16], TV[i][15:8]);
      rd(TV[i][23:16], q);
      chk(q, TV[i][7:0], "register access");
    end
  endtask

  task automatic t_rate();
    logic [7:0] q;
    logic v;
    int n;
    foreach (RT[i]) begin
      wr(MC, {4'h0, RT[i][13:12], 2'b00});
      wr(RB, {4'h0, RT[i][11:8]});
      wr(CS, 8'h80);
      wait_out(n);
      wait_out(n);
      chk(8'(n), RT[i][7:0], "toggle period");
      rd(CS, q);
      chk(q, 8'h84, "wrap flag while running");
      chk(irq, 1'b0, "interrupt while not allowed");
      wr(CS, 8'h00);
      rd(CS, q);
      chk(q, 8'h00, "stop and clear");
      @(negedge clk_i);
      v = pout;
      repeat (80) @(negedge clk_i);
      chk(pout, v, "output held after stop");
    end
  endtask

  task automatic t_oneshot();
    logic [7:0] q;
    int n;
    wr(MC, 8'h40);
    wr(RB, 8'h03);
    wr(CS, 8'h80);
    wait_out(n);
    rd(CS, q);
    chk(q, 8'h04, "one-shot stops with wrap");
    rd(MC, q);
    chk(q, 8'h60, "one-shot toggled output bit");
    wr(CS, 8'h24);
    repeat (3) @(negedge clk_i);
    chk(irq, 1'b1, "late allow raises interrupt");
    wr(CS, 8'h20);
    repeat (3) @(negedge clk_i);
    chk(irq, 1'b0, "clear drops interrupt");
  endtask

  task automatic t_meas();
    logic [7:0] q, e, d;
    int k;
    foreach (MT[i]) begin
      @(posedge clk_i);
      hi_len <= MT[i][47:32];
      lo_len <= MT[i][31:16];
      src_en <= 1'b1;
      wr(MC, {6'b100000, MT[i][49:48]});
      rd(RB, q);
      wr(CS, 8'h00);
      k = 0;
      while (pin !== 1'b1 && k < 200) begin
        @(negedge clk_i);
        k++;
      end
      wr(CS, 8'hA0);
      k = 0;
      do begin
        rd(CS, q);
        k++;
      end while (q[0] !== 1'b1 && k < 500);
      chk(q, {5'b10100, MT[i][8], 2'b11}, "completion flags");
      @(negedge clk_i);
      chk(irq, 1'b1, "completion interrupt");
      if (i == 0) begin
        @(posedge clk_i);
        hi_len <= 16'h0006;
        repeat (150) @(negedge clk_i);
        // read only after a completion, so no new capture races the read
        wait (pin === 1'b1);
        wait (pin === 1'b0);
        repeat (6) @(negedge clk_i);
      end
      e = 8'hFF - MT[i][7:0];
      rd(RB, q);
      d = q - e + 8'h01;
      samples_checked++;
      if (d !== 8'h00 && d !== 8'h01 && d !== 8'h02) fail("captured width");
      rd(CS, q);
      chk(q[0], 1'b0, "capture read clears held flag");
      wr(CS, 8'h00);
      src_en <= 1'b0;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    fail("watchdog expired");
    final_report();
  end

  initial begin
    req = '0;
    req.hsel = 1'b1;
    req.hsize = 3'h2;
    rst_i = 1'b1;
    src_en = 1'b0;
    hi_len = 16'h0014;
    lo_len = 16'h0028;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_rate();
    t_oneshot();
    t_meas();
    final_report();
  end
endmodule // tb
`default_nettype wire
